/* File: hw/ffp_frame_fifo.sv */
/*
  Port and configuration front end of a video frame FIFO memory:
  write ports, read port with latency pipe, external pointer override,
  depth-expansion slice ownership and a two-wire configuration slave.
  Assumes all pins are asynchronous to clk_sys and that pin clocks
  run well below a quarter of clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Behaviour
// - Write: start, address with low direction bit, index; each byte acked.
// - Index advances by one after each acknowledged data byte.
// - Read returns indexed register, then next one per master ack.
// - Staged values reach working registers on zero written to 03F.
// - Cascaded single-channel device serves its 1/N slice and drives only then.
// - Chain register holds position in [3:0] and device count.
// - Write clock a edge with enable low latches data, advances pointer.
// - Dual: write clock b writes channel b; single: it is ignored.
// - Read edge with read and output enable low reads and advances.
// - Wide single widths use both halves; narrow use lower port.
// - Dual: port b is channel b's 12-bit port; bit 11 is MSB.
// - Slave only; serial clock is an input.
// - External pointer is available in single-channel only.
// - Pointer linear by default, or row and column scaled by row length.
// - External pointer captured on write clock a; selector picks target.
// - Selector low loads write pointer, high loads read pointer.
// - Four-bit organization selects width and channel count.
// - Acknowledge only a first byte matching the slave id.
// - Read data appears after eight further read edges with enable low.
module ffp_frame_fifo
  import ffp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic write_clock_a,
  input wire logic write_clock_b,
  input wire logic read_clock,
  input wire logic write_enable_a_n,
  input wire logic write_enable_b_n,
  input wire logic [1:0] read_enable_n,
  input wire logic [1:0] output_enable_n,
  input wire logic write_pointer_load_a_n,
  input wire logic read_pointer_load_n,
  input wire logic override_target_select_pin,
  input wire logic [11:0] data_in_a,
  input wire logic [11:0] data_in_b,
  input wire logic [23:0] ext_pointer,
  input wire logic [3:0] organization,
  input wire logic [6:0] serial_slave_id,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [1:0][11:0] data_out_port,
  output logic [1:0] data_out_oe
);
  ffp_state_type st;
  ffp_state_type next_st;
  ffp_pin_type raw;
  ffp_pin_type pin;
  ffp_pin_type rise;
  ffp_pin_type fall;
  logic [11:0] mem [2][`FFP_MEM_DEPTH];
  logic [1:0] mem_we;
  logic [1:0][`FFP_MEM_AW-1:0] mem_wa;
  logic [1:0][11:0] mem_wd;
  logic [1:0] wr_ev;
  logic [1:0] shift;
  logic [1:0] acc;
  logic [1:0][23:0] wr_addr;
  logic [1:0][23:0] rd_addr;
  logic start;
  logic stop;
  logic dual;
  logic wide;
  logic two_d;
  logic [11:0] row_len;
  logic ovr_w;
  logic ovr_r;
  logic we_own;
  logic upd;
  logic wr_byte;
  logic do_load;
  logic [7:0] rd_byte;
  logic override_target_select;
  ffp_pipe_type entry;
  logic ctl;

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  // Every pin passes two flops before any logic looks at it.
  assign raw = '{wclk_a: write_clock_a, wclk_b: write_clock_b,
                 rclk: read_clock, scl: scl, sda: sda_in,
                 we_a_n: write_enable_a_n, we_b_n: write_enable_b_n,
                 ren_n: read_enable_n, oe_n: output_enable_n,
                 wload_a_n: write_pointer_load_a_n,
                 rload_n: read_pointer_load_n,
                 tsel: override_target_select_pin,
                 din_a: data_in_a, din_b: data_in_b,
                 ext_addr: ext_pointer, org: organization,
                 slave_id: serial_slave_id};

  ffp_sync #(.W($bits(ffp_pin_type))) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .din(raw),
    .sync(pin),
    .rise(rise),
    .fall(fall)
  );

  //////////////////////////////////////////////////////////////////////
  // Helpers.

  // Linear or row/column pointer mapping.
  function automatic logic [23:0] map_addr(input logic [23:0] a,
                                           input logic td,
                                           input logic [11:0] rl);
    logic [23:0] prod;
    prod = a[23:12] * rl;
    return td ? prod + {12'h000, a[11:0]} : a;
  endfunction : map_addr

  // True when a pointer falls in this device's slice of the chain.
  function automatic logic owns(input logic [23:0] p,
                                input logic [7:0] chain);
    logic [11:0] region;
    region = p[23:16] * chain[7:4];
    return (chain[7:4] <= 4'h1) || (region[11:8] == chain[3:0]);
  endfunction : owns

  //////////////////////////////////////////////////////////////////////
  // Configuration decode from the organization pins and the configuration registers.

  // Organization bits and the committed configuration.
  always_comb begin
    dual = pin.org[`FFP_ORG_DUAL_BIT];
    wide = !dual && pin.org[`FFP_ORG_WIDE_BIT];
    two_d = st.working[`FFP_REG_MODE][`FFP_TWO_D_BIT];
    row_len = {st.working[`FFP_REG_ROW_HI][3:0],
               st.working[`FFP_REG_ROW_LO]};
    override_target_select = pin.tsel;
    rd_byte = (st.index < 8'(`FFP_NUM_REGS)) ?
              st.staged[st.index[3:0]] : 8'h00;
  end

  //////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    next_st = st;
    upd = 1'b0;
    wr_byte = 1'b0;
    do_load = 1'b0;
    start = fall.sda && pin.scl;
    stop = rise.sda && pin.scl;
    ovr_w = 1'b0;
    ovr_r = 1'b0;
    we_own = 1'b0;
    mem_we = 2'b00;
    mem_wa = '0;
    mem_wd = '0;
    wr_ev = 2'b00;
    wr_addr = st.wp;
    rd_addr = st.rp;
    shift = 2'b00;
    acc = 2'b00;
    entry = '0;
    ctl = 1'b0;

    // Two-wire slave: SCL is only ever sampled, never driven.
    if (start) begin
      next_st.i2c = I2C_ADDR;
      next_st.bitcnt = 4'h0;
      next_st.sda_oe = 1'b0;
      next_st.got_index = 1'b0;
    end else if (stop) begin
      next_st.i2c = I2C_IDLE;
      next_st.sda_oe = 1'b0;
    end else begin
      case (st.i2c)
        I2C_ADDR, I2C_RX: begin
          if (rise.scl) begin
            next_st.shreg = {st.shreg[6:0], pin.sda};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end else if (fall.scl && st.bitcnt == 4'h8) begin
            next_st.sda_oe = 1'b1;
            next_st.i2c = I2C_ACK;
            if (st.i2c == I2C_ADDR) begin
              next_st.is_read = st.shreg[0];
              if (st.shreg[7:1] != pin.slave_id) begin
                next_st.i2c = I2C_IDLE;
                next_st.sda_oe = 1'b0;
              end
            end else if (!st.got_index) begin
              next_st.index = st.shreg;
              next_st.got_index = 1'b1;
            end else begin
              wr_byte = 1'b1;
              next_st.index = st.index + 8'h01;
              if (st.index == `FFP_REG_UPDATE) begin
                upd = (st.shreg == `FFP_UPDATE_CODE);
              end else if (st.index < 8'(`FFP_NUM_REGS)) begin
                next_st.staged[st.index[3:0]] = st.shreg;
              end
            end
          end
        end
        I2C_ACK: begin
          if (fall.scl) begin
            next_st.bitcnt = 4'h0;
            if (st.is_read) begin
              do_load = 1'b1;
            end else begin
              next_st.sda_oe = 1'b0;
              next_st.i2c = I2C_RX;
            end
          end
        end
        I2C_TX: begin
          if (fall.scl) begin
            next_st.bitcnt = st.bitcnt + 4'h1;
            if (st.bitcnt == 4'h7) begin
              next_st.sda_oe = 1'b0;
              next_st.i2c = I2C_MACK;
            end else begin
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.sda_oe = !st.shreg[6];
            end
          end
        end
        I2C_MACK: begin
          if (rise.scl) begin
            next_st.mack = !pin.sda;
          end else if (fall.scl) begin
            next_st.bitcnt = 4'h0;
            if (st.mack) begin
              do_load = 1'b1;
            end else begin
              next_st.i2c = I2C_IDLE;
            end
          end
        end
        default: begin
          next_st.i2c = I2C_IDLE;
        end
      endcase
    end

    // Load the indexed register for transmit and move the index on.
    if (do_load) begin
      next_st.shreg = rd_byte;
      next_st.sda_oe = !rd_byte[7];
      next_st.index = st.index + 8'h01;
      next_st.i2c = I2C_TX;
    end

    // Update command commits every staged value at once.
    if (upd) begin
      next_st.working = st.staged;
    end

    // Write side: channel a on write clock a, channel b on b in dual.
    if (rise.wclk_a) begin
      next_st.ext_lat = pin.ext_addr;
    end
    wr_ev[0] = rise.wclk_a && !pin.we_a_n;
    wr_ev[1] = dual && rise.wclk_b && !pin.we_b_n;
    ovr_w = !dual && !override_target_select
            && !pin.wload_a_n;
    if (ovr_w) begin
      wr_addr[0] = map_addr(pin.ext_addr, two_d, row_len);
    end
    we_own = wr_ev[0] && (dual || owns(wr_addr[0],
             st.working[`FFP_REG_CHAIN]));
    for (int ch = 0; ch < 2; ch++) begin
      if (wr_ev[ch]) begin
        next_st.wp[ch] = wr_addr[ch] + 24'h000001;
      end
    end
    mem_we[0] = we_own;
    mem_wa[0] = wr_addr[0][`FFP_MEM_AW-1:0];
    mem_wd[0] = pin.din_a;
    // Upper half follows channel a when single, else its own port.
    mem_we[1] = dual ? wr_ev[1] : we_own;
    mem_wa[1] = dual ? wr_addr[1][`FFP_MEM_AW-1:0] :
                wr_addr[0][`FFP_MEM_AW-1:0];
    mem_wd[1] = (dual || wide) ? pin.din_b : 12'h000;

    // Read side: access, pointer advance and latency pipe per channel.
    ovr_r = !dual && override_target_select && !pin.rload_n;
    for (int ch = 0; ch < 2; ch++) begin
      ctl = dual && (ch == 1);
      shift[ch] = rise.rclk && !pin.ren_n[ctl];
      acc[ch] = shift[ch] && !pin.oe_n[ctl];
      if (!dual) begin
        rd_addr[ch] = ovr_r ?
          map_addr(st.ext_lat, two_d, row_len) : st.rp[0];
      end
      entry.valid = acc[ch];
      entry.own = dual || owns(rd_addr[ch],
                  st.working[`FFP_REG_CHAIN]);
      entry.data = mem[ch][rd_addr[ch][`FFP_MEM_AW-1:0]];
      if (acc[ch]) begin
        next_st.rp[ch] = rd_addr[ch] + 24'h000001;
      end
      if (shift[ch]) begin
        next_st.pipe[ch] = {st.pipe[ch][`FFP_READ_LAT-2:0], entry};
        if (st.pipe[ch][`FFP_READ_LAT-1].valid) begin
          next_st.dout[ch] = st.pipe[ch][`FFP_READ_LAT-1].data;
          next_st.dout_oe[ch] = st.pipe[ch][`FFP_READ_LAT-1].own
                                && !pin.oe_n[ctl];
        end else begin
          next_st.dout_oe[ch] = st.dout_oe[ch] && !pin.oe_n[ctl];
        end
      end else if (pin.oe_n[ctl]) begin
        next_st.dout_oe[ch] = 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registers and memory.

  // State register.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // One write port per 12-bit half of the memory.
  for (genvar g = 0; g < 2; g++) begin : g_mem
    always_ff @(posedge clk_sys) begin
      if (mem_we[g]) begin
        mem[g][mem_wa[g]] <= mem_wd[g];
      end
    end
  end

  // Outputs come straight from the state register.
  assign sda_out = st.sda_lo;
  assign sda_oe = st.sda_oe;
  assign data_out_port = st.dout;
  assign data_out_oe = st.dout_oe;

  //////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  update_commit_a: assert property (upd |=> st.working == $past(st.staged))
    else $error("update did not commit staged registers");
  index_step_a: assert property
    (wr_byte |=> st.index == $past(st.index) + 8'h01)
    else $error("register index did not advance");
  id_mismatch_a: assert property (st.i2c == I2C_ADDR && fall.scl
    && st.bitcnt == 4'h8 && st.shreg[7:1] != pin.slave_id && !start
    && !stop |=> !st.sda_oe && st.i2c == I2C_IDLE)
    else $error("acknowledged a foreign address");
  sda_timing_a: assert property ($changed(st.sda_oe) |->
    $past(fall.scl) || $past(start) || $past(stop))
    else $error("data line changed outside clock low");
  write_step_a: assert property (wr_ev[0] && !ovr_w |=>
    st.wp[0] == $past(st.wp[0]) + 24'h000001)
    else $error("write pointer did not advance");
  clock_b_ignored_a: assert property (!dual && !wr_ev[0] |=>
    $stable(st.wp[1]))
    else $error("channel b pointer moved in single mode");
  read_capture_a: assert property (acc[0] |=> st.pipe[0][0].valid
    ##1 !shift[0] [*7] |-> st.pipe[0][0].valid)
    else $error("read access not held in latency pipe");
  slice_drive_a: assert property ($rose(st.dout_oe[0]) |->
    $past(st.pipe[0][`FFP_READ_LAT-1].own))
    else $error("drove output outside owned slice");
  no_override_dual_a: assert property (dual && wr_ev[0] |=>
    st.wp[0] == $past(st.wp[0]) + 24'h000001)
    else $error("external pointer used in dual mode");
  read_step_a: assert property (acc[0] && !ovr_r |=>
    st.rp[0] == $past(st.rp[0]) + 24'h000001)
    else $error("read pointer did not advance");

  multi_write_c: cover property (wr_byte ##[1:400] wr_byte);
  read_byte_c: cover property (do_load ##[1:400] st.i2c == I2C_MACK);
  update_c: cover property (upd);
  data_out_c: cover property ($rose(st.dout_oe[0]));
endmodule : ffp_frame_fifo

`default_nettype wire

/* File: hw/ffp_params.svh */
/*
  Constants of the frame FIFO port and configuration front end.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef FFP_PARAMS_SVH
`define FFP_PARAMS_SVH

// Local memory model: address bits and depth per channel.
`define FFP_MEM_AW 6
`define FFP_MEM_DEPTH 64
// Configuration register file and its offsets.
`define FFP_NUM_REGS 16
`define FFP_REG_MODE 8'h00
`define FFP_REG_ROW_LO 8'h01
`define FFP_REG_ROW_HI 8'h02
`define FFP_REG_CHAIN 8'h0C
`define FFP_REG_UPDATE 8'h3F
`define FFP_UPDATE_CODE 8'h00
`define FFP_REG_RESET 8'h00
// Field positions.
`define FFP_TWO_D_BIT 0
`define FFP_ORG_DUAL_BIT 2
`define FFP_ORG_WIDE_BIT 3
// Read-clock edges from memory access to the output port.
`define FFP_READ_LAT 8

`endif

/* File: hw/ffp_pkg.sv */
/*
  Types of the frame FIFO port and configuration front end.
  Assumes ffp_params.svh is on the include path.
*/
package ffp_pkg;
  `include "ffp_params.svh"

  // Two-wire slave sequencer states.
  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_RX = 3'b010,
    I2C_ACK = 3'b011,
    I2C_TX = 3'b100,
    I2C_MACK = 3'b101
  } ffp_i2c_state_type;

  // All pin inputs, in one bundle for the synchroniser.
  typedef struct packed {
    logic wclk_a;
    logic wclk_b;
    logic rclk;
    logic scl;
    logic sda;
    logic we_a_n;
    logic we_b_n;
    logic [1:0] ren_n;
    logic [1:0] oe_n;
    logic wload_a_n;
    logic rload_n;
    logic tsel;
    logic [11:0] din_a;
    logic [11:0] din_b;
    logic [23:0] ext_addr;
    logic [3:0] org;
    logic [6:0] slave_id;
  } ffp_pin_type;

  // One stage of the read latency pipe.
  typedef struct packed {
    logic valid;
    logic own;
    logic [11:0] data;
  } ffp_pipe_type;

  // Whole state of the front end.
  typedef struct packed {
    ffp_i2c_state_type i2c;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic is_read;
    logic got_index;
    logic mack;
    logic sda_oe;
    logic sda_lo;
    logic [7:0] index;
    logic [`FFP_NUM_REGS-1:0][7:0] staged;
    logic [`FFP_NUM_REGS-1:0][7:0] working;
    logic [23:0] ext_lat;
    logic [1:0][23:0] wp;
    logic [1:0][23:0] rp;
    ffp_pipe_type [1:0][`FFP_READ_LAT-1:0] pipe;
    logic [1:0][11:0] dout;
    logic [1:0] dout_oe;
  } ffp_state_type;
endpackage : ffp_pkg

/* File: hw/ffp_sync.sv */
/*
  Two-flop synchroniser with edge detection for a bundle of pins.
  Assumes all inputs are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module ffp_sync #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] sync,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } ffp_sync_state_type;

  ffp_sync_state_type st;
  ffp_sync_state_type next_st;

  // The first stage feeds only the second; edges compare later stages.
  always_comb begin
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  // State register.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Synchronised level and one-cycle edge pulses.
  assign sync = st.s2;
  assign rise = st.s2 & ~st.s3;
  assign fall = ~st.s2 & st.s3;
endmodule : ffp_sync

`default_nettype wire

/* File: sim/ffp_far_end.sv */
/*
  Far-end model: a two-wire master and the video pin clocks.
  Assumes pull-ups on SDA and SCL and a 125 MHz clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module ffp_far_end (
  input wire logic clk_sys,
  input wire logic sda_oe,
  output logic sda_in,
  output logic scl,
  output logic write_clock_a,
  output logic write_clock_b,
  output logic read_clock
);
  logic drive_low = 1'b0;
  logic [2:0] pin_clk = 3'h0;

  // Wired-AND SDA; once both ends release it the pull-up wins.
  assign sda_in = ~(drive_low | sda_oe);
  // Pin clocks stand still between pulses.
  assign write_clock_a = pin_clk[0];
  assign write_clock_b = pin_clk[1];
  assign read_clock = pin_clk[2];
  initial scl = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // One third of a serial bit, long enough for the slave's synchroniser.
  task automatic quarter();
    repeat (10) @(negedge clk_sys);
  endtask : quarter

  // Start or repeated start: SDA falls while SCL is high.
  task automatic start();
    drive_low = 1'b0;
    quarter();
    scl = 1'b1;
    quarter();
    drive_low = 1'b1;
    quarter();
    scl = 1'b0;
  endtask : start

  // Stop: SDA rises while SCL is high.
  task automatic stop();
    drive_low = 1'b1;
    quarter();
    scl = 1'b1;
    quarter();
    drive_low = 1'b0;
    quarter();
  endtask : stop

  // One bit: SDA changes only while SCL is low, sampled while high.
  task automatic bit_io(input logic v, output logic s);
    drive_low = ~v;
    quarter();
    scl = 1'b1;
    quarter();
    s = sda_in;
    quarter();
    scl = 1'b0;
  endtask : bit_io

  // Sends a byte MSB first and returns the slave's acknowledge.
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send

  // Receives a byte; last releases SDA as a not-acknowledge.
  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask : recv

  // One 125 ns pin clock period, rising well after data settled.
  task automatic pulse(input int which);
    @(negedge clk_sys);
    #62.5;
    pin_clk[which] = 1'b1;
    #62.5;
    pin_clk[which] = 1'b0;
  endtask : pulse
endmodule : ffp_far_end

`default_nettype wire

/* File: sim/tb.sv */
/*
  Self-checking bench of the frame FIFO front end.
  Assumes ffp_pkg, ffp_frame_fifo and ffp_far_end are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ffp_params.svh"

module tb;
  localparam logic [6:0] SLAVE_ID = 7'h2A;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic we_a_n = 1'b1, we_b_n = 1'b1, tsel = 1'b0;
  logic wload_n = 1'b1, rload_n = 1'b1;
  logic [1:0] ren_n = 2'h3, oe_n = 2'h0;
  logic [11:0] din_a = 12'h000, din_b = 12'h000;
  logic [23:0] ext_ptr = 24'h000000;
  logic [3:0] org = 4'h0;
  wire scl, sda_line, wclk_a, wclk_b, rclk, sda_oe, sda_out;
  wire [1:0][11:0] data_out_port;
  wire [1:0] data_out_oe;
  int errors = 0;
  int n_tests = 0;

  ffp_frame_fifo u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .write_clock_a(wclk_a), .write_clock_b(wclk_b), .read_clock(rclk),
    .write_enable_a_n(we_a_n), .write_enable_b_n(we_b_n),
    .read_enable_n(ren_n), .output_enable_n(oe_n),
    .write_pointer_load_a_n(wload_n), .read_pointer_load_n(rload_n),
    .override_target_select_pin(tsel), .data_in_a(din_a),
    .data_in_b(din_b), .ext_pointer(ext_ptr), .organization(org),
    .serial_slave_id(SLAVE_ID), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .data_out_port(data_out_port),
    .data_out_oe(data_out_oe));

  ffp_far_end u_far (.clk_sys(clk_sys), .sda_oe(sda_oe),
    .sda_in(sda_line), .scl(scl), .write_clock_a(wclk_a),
    .write_clock_b(wclk_b), .read_clock(rclk));

  // System clock, 8 ns period.
  always #4 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [23:0] exp,
    input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // Start, own address for writing and a register index.
  task automatic open_write(input logic [7:0] idx);
    logic ack;
    u_far.start();
    u_far.send({SLAVE_ID, 1'b0}, ack);
    check("address ack", 24'h1, {23'h0, ack});
    u_far.send(idx, ack);
    check("index ack", 24'h1, {23'h0, ack});
  endtask : open_write

  // Presents a word on port a and gives one write clock.
  task automatic put(input logic [11:0] a);
    @(negedge clk_sys);
    din_a = a;
    u_far.pulse(0);
  endtask : put

  // Gives n read clock rises.
  task automatic reads(input int n);
    repeat (n) u_far.pulse(2);
  endtask : reads

  // Writes {hi, w} at wptr, then latches rptr on a bare write clock,
  // loads it into the read pointer and reads the word back from there.
  task automatic override(input logic [23:0] wptr,
    input logic [23:0] rptr, input logic [11:0] w, input logic [11:0] hi);
    @(negedge clk_sys);
    tsel = 1'b0;
    wload_n = 1'b0;
    we_a_n = 1'b0;
    ext_ptr = wptr;
    din_b = hi;
    put(w);
    @(negedge clk_sys);
    wload_n = 1'b1;
    we_a_n = 1'b1;
    din_b = 12'h000;
    ext_ptr = rptr;
    u_far.pulse(0);
    @(negedge clk_sys);
    tsel = 1'b1;
    rload_n = 1'b0;
    reads(1);
    @(negedge clk_sys);
    rload_n = 1'b1;
    reads(`FFP_READ_LAT);
    check("ovr word", {12'h0, w}, {12'h0, data_out_port[0]});
    check("ovr hi", {12'h0, hi}, {12'h0, data_out_port[1]});
    check("ovr drive", 24'h1, {23'h0, data_out_oe[0]});
  endtask : override

  ////////////////////////////////////////////////////////////////////////
  // Multi-byte write, read back from the index, foreign address.
  task automatic t_registers();
    logic ack;
    logic [7:0] b;
    open_write(`FFP_REG_CHAIN);
    u_far.send(8'h21, ack);
    check("data ack", 24'h1, {23'h0, ack});
    u_far.send(8'h5A, ack);
    u_far.stop();
    open_write(`FFP_REG_CHAIN);
    u_far.start();
    u_far.send({SLAVE_ID, 1'b1}, ack);
    check("read address ack", 24'h1, {23'h0, ack});
    u_far.recv(1'b0, b);
    check("chain register", 24'h21, {16'h0, b});
    check("sda level", 24'h0, {23'h0, sda_out});
    u_far.recv(1'b1, b);
    check("next register", 24'h5A, {16'h0, b});
    u_far.stop();
    u_far.start();
    u_far.send({~SLAVE_ID, 1'b0}, ack);
    check("foreign address ack", 24'h0, {23'h0, ack});
    u_far.stop();
  endtask : t_registers

  // Dual channels: port b on its own write clock and read enable.
  task automatic t_dual();
    @(negedge clk_sys);
    org = 4'h4;
    din_a = 12'h000;
    din_b = 12'hB5C;
    we_b_n = 1'b0;
    ren_n = 2'b01;
    u_far.pulse(1);
    @(negedge clk_sys);
    we_b_n = 1'b1;
    din_b = 12'h000;
    reads(`FFP_READ_LAT + 1);
    check("channel b word", 24'hB5C, {12'h0, data_out_port[1]});
    check("channel b drive", 24'h1, {23'h0, data_out_oe[1]});
  endtask : t_dual

  // Narrow single channel stream through the eight-rise read pipe.
  task automatic t_stream();
    @(negedge clk_sys);
    org = 4'h0;
    we_a_n = 1'b0;
    ren_n = 2'b00;
    put(12'hA11);
    put(12'hB22);
    put(12'hC33);
    @(negedge clk_sys);
    we_a_n = 1'b1;
    reads(`FFP_READ_LAT);
    check("early drive", 24'h0, {23'h0, data_out_oe[0]});
    reads(1);
    check("first word", 24'hA11, {12'h0, data_out_port[0]});
    check("narrow upper half", 24'h0, {12'h0, data_out_port[1]});
    check("staged chain idle", 24'h1, {23'h0, data_out_oe[0]});
    reads(1);
    check("second word", 24'hB22, {12'h0, data_out_port[0]});
    reads(1);
    check("third word", 24'hC33, {12'h0, data_out_port[0]});
    override(24'h000005, 24'h000005, 12'h5E5, 12'h000);
  endtask : t_stream

  // Update commits chain placement and two-dimensional mapping at once:
  // device 1 of 2 owns the upper half, and rows are 12'h801 words long.
  task automatic t_chain();
    logic ack;
    open_write(`FFP_REG_MODE);
    u_far.send(8'h01, ack);
    u_far.send(8'h01, ack);
    u_far.send(8'h08, ack);
    u_far.stop();
    open_write(`FFP_REG_UPDATE);
    u_far.send(`FFP_UPDATE_CODE, ack);
    u_far.stop();
    reads(`FFP_READ_LAT + 1);
    check("foreign slice drive", 24'h0, {22'h0, data_out_oe});
    // Row FFF column 011 and row FFE column 812 map to one word.
    override(24'hFFF011, 24'hFFE812, 12'h7E7, 12'h000);
    @(negedge clk_sys);
    org = 4'h8;
    override(24'hFFF012, 24'hFFE813, 12'h3C4, 12'hD2E);
  endtask : t_chain

  // Cuts a hang short.
  initial begin
    #400_000;
    errors++;
    stop_test();
  end

  // Reset, then the scenarios in order.
  initial begin
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    t_registers();
    t_dual();
    t_stream();
    t_chain();
    stop_test();
  end
endmodule : tb

`default_nettype wire
